// ### core/position_datum_scale_stopwatch.sv
// datum, scale, unit and stopwatch logic for a two-axis readout
`timescale 1ns/1ps

// What this block does
// - coupled reset zeroes both axis displays
// - coupled output shows formula of zeroed axes
// - coupled enter loads first, clears second
// - coupled preset loads datum value, clears second
// - pending entry flashes set, applied on enter
// - encoder movement multiplied by active factor
// - factor magnitude 0.1 to 10, on/off
// - scaling indicator when factor not one and scaling is on for an axis
// - factor kept in nonvolatile storage
// - scaling enabled only on linear axes
// - negative factor mirrors and scales together
// - unit toggles mm/inch, restored at power-up
// - angle format cycles through three encodings
// - entered datum preset stored on enter
// - stopwatch counts h:m:s from zero
// - stopwatch accumulates, stop holds value
// - start/stop toggles, running reported
// - stopwatch reset clears and stops
// - stopwatch requests act immediately
// - field shows m:s below hour, else h:m
// - two datums per axis, selectable
module position_datum_scale_stopwatch
    import datum_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES,
    parameter int FLASH_LEN = FLASH_CYCLES
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clock_en,
    input wire logic [7:0] address,
    input wire logic [31:0] write_data,
    input wire logic write_strobe,
    input wire logic read_strobe,
    output logic [31:0] read_data,
    input wire logic signed [7:0] first_axis_delta,
    input wire logic signed [7:0] second_axis_delta,
    input wire logic ext_reset_pin,
    input wire logic ext_preset_pin,
    input wire logic signed [31:0] nv_scale_in,
    input wire logic nv_inch_in,
    input wire logic [2:0] nv_angle_in,
    output logic nv_write,
    output logic signed [31:0] nv_scale_out,
    output logic nv_inch_out,
    output logic [2:0] nv_angle_out,
    output logic set_flash,
    output logic scale_indicator,
    output logic watch_running,
    output logic [5:0] watch_field_hi,
    output logic [5:0] watch_field_lo,
    output logic watch_field_hours
);

    typedef enum logic [1:0] {
        SW_STOPPED = 2'h1,
        SW_RUNNING = 2'h2
    } watch_e;

    // scaled movement in millionths of a count
    function automatic logic signed [31:0] scale_move(
        input logic signed [7:0] delta,
        input logic signed [31:0] factor,
        input logic enabled
    );
        logic signed [39:0] product;
        product = 40'(delta) * 40'(enabled ? factor : SCALE_ONE);
        return product[31:0];
    endfunction

    // accepted range, sign ignored so mirroring stays legal
    function automatic logic factor_ok(input logic signed [31:0] f);
        logic signed [31:0] mag;
        mag = (f < 0) ? -f : f;
        return (mag >= SCALE_MIN) && (mag <= SCALE_MAX);
    endfunction

    logic [6:0] ctrl; // control bits
    logic [1:0] axis_linear; // axis type, 1 = linear encoder
    logic signed [31:0] entry; // keyed value waiting for enter
    logic entry_pending; // entry not yet confirmed
    logic signed [31:0] scale_factor; // active factor, millionths
    logic signed [31:0] preset_value; // stored datum preset
    logic signed [31:0] formula_k; // constant term of coupled formula
    logic signed [31:0] raw_pos [2]; // scaled encoder positions
    logic signed [31:0] offset [2][2]; // [axis][datum] offsets
    logic inch_mode; // linear unit
    angle_e angle_fmt; // angular format
    logic restored; // nonvolatile settings taken
    logic [2:0] reset_sync; // pin synchroniser plus edge history
    logic [2:0] preset_sync;
    logic [31:0] flash_count;
    logic flash_phase;
    watch_e watch_state;
    logic [31:0] tick_count;
    logic [5:0] seconds;
    logic [5:0] minutes;
    logic [7:0] hours;

    logic do_write;
    logic [8:0] cmd;
    logic cmd_reset;
    logic cmd_preset;
    logic signed [31:0] disp [2];
    logic signed [31:0] coupled_value;
    logic datum_sel;
    logic target;
    logic tick;

    assign do_write = clock_en && write_strobe;
    // commands last the write cycle
    assign cmd = (do_write && address == ADDR_CMD) ? write_data[8:0] : 9'h000;
    // pin rising edge: second flop against third
    assign cmd_reset = cmd[CMD_RESET] || (clock_en && reset_sync[1] && !reset_sync[2]);
    assign cmd_preset = cmd[CMD_PRESET] || (clock_en && preset_sync[1] && !preset_sync[2]);
    assign datum_sel = ctrl[CTRL_DATUM];
    assign target = ctrl[CTRL_TARGET];
    assign tick = (watch_state == SW_RUNNING) && (tick_count == 32'(TICK_LEN - 1));

    // display: position against chosen datum
    always_comb begin
        for (int a = 0; a < 2; a++) begin
            disp[a] = raw_pos[a] + offset[a][datum_sel];
        end
    end

    // coupled formula over both displays, or over the first alone
    always_comb begin
        case (ctrl[CTRL_FORM_LO +: 2])
            FORM_SUM: coupled_value = disp[0] + disp[1] + formula_k;
            FORM_DIFF: coupled_value = disp[0] - disp[1] + formula_k;
            FORM_FIRST: coupled_value = disp[0] + formula_k;
            default: coupled_value = disp[0] + disp[1] + formula_k;
        endcase
    end

    // pins pass two flops before any logic
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            reset_sync <= 3'h0;
            preset_sync <= 3'h0;
        end else if (clock_en) begin
            reset_sync <= {reset_sync[1:0], ext_reset_pin};
            preset_sync <= {preset_sync[1:0], ext_preset_pin};
        end
    end

    // control register, scaling refused on non-linear axes
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ctrl <= 7'h00;
            axis_linear <= 2'h3;
            formula_k <= 32'sh0;
        end else if (do_write) begin
            if (address == ADDR_CTRL) begin
                ctrl[4:0] <= write_data[4:0];
                ctrl[CTRL_SCALE1] <= write_data[CTRL_SCALE1] && axis_linear[0];
                ctrl[CTRL_SCALE2] <= write_data[CTRL_SCALE2] && axis_linear[1];
            end else if (address == ADDR_AXIS_CFG) begin
                axis_linear <= write_data[1:0];
                // a non-linear axis drops its scaling
                ctrl[CTRL_SCALE1] <= ctrl[CTRL_SCALE1] && write_data[0];
                ctrl[CTRL_SCALE2] <= ctrl[CTRL_SCALE2] && write_data[1];
            end else if (address == ADDR_FORMULA_K) begin
                formula_k <= write_data;
            end
        end
    end

    // keyed entry: held until enter or cancel
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            entry <= 32'sh0;
            entry_pending <= 1'b0;
        end else if (do_write && address == ADDR_ENTRY) begin
            entry <= write_data;
            entry_pending <= 1'b1;
        end else if (cmd[CMD_ENTER_DISP] || cmd[CMD_ENTER_PRESET] || cmd[CMD_CANCEL]) begin
            entry_pending <= 1'b0;
        end
    end

    // set indicator flashes while entry waits
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            flash_count <= 32'h0;
            flash_phase <= 1'b0;
        end else if (clock_en) begin
            if (!entry_pending) begin
                flash_count <= 32'h0;
                flash_phase <= 1'b1;
            end else if (flash_count == 32'(FLASH_LEN - 1)) begin
                flash_count <= 32'h0;
                flash_phase <= !flash_phase;
            end else begin
                flash_count <= flash_count + 32'h1;
            end
        end
    end
    assign set_flash = entry_pending && flash_phase;

    // stored datum preset for later presets
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            preset_value <= 32'sh0;
        end else if (cmd[CMD_ENTER_PRESET] && entry_pending) begin
            preset_value <= entry;
        end
    end

    // scaled movement, mirrored by a negative factor
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            raw_pos[0] <= 32'sh0;
            raw_pos[1] <= 32'sh0;
        end else if (clock_en) begin
            raw_pos[0] <= raw_pos[0]
                + scale_move(first_axis_delta, scale_factor, ctrl[CTRL_SCALE1]);
            raw_pos[1] <= raw_pos[1]
                + scale_move(second_axis_delta, scale_factor, ctrl[CTRL_SCALE2]);
        end
    end

    // datum offsets on the selected datum
    // movement in the same cycle lands after the new datum
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            for (int a = 0; a < 2; a++) begin
                offset[a][0] <= 32'sh0;
                offset[a][1] <= 32'sh0;
            end
        end else if (ctrl[CTRL_COUPLED]) begin
            // coupled mode: both axes move together
            if (cmd_reset) begin
                offset[0][datum_sel] <= -raw_pos[0];
                offset[1][datum_sel] <= -raw_pos[1];
            end else if (cmd_preset) begin
                offset[0][datum_sel] <= preset_value - raw_pos[0];
                offset[1][datum_sel] <= -raw_pos[1];
            end else if (cmd[CMD_ENTER_DISP] && entry_pending) begin
                offset[0][datum_sel] <= entry - raw_pos[0];
                offset[1][datum_sel] <= -raw_pos[1];
            end
        end else begin
            // single mode: target axis only
            if (cmd_reset) begin
                offset[target][datum_sel] <= -raw_pos[target];
            end else if (cmd_preset) begin
                offset[target][datum_sel] <= preset_value - raw_pos[target];
            end else if (cmd[CMD_ENTER_DISP] && entry_pending) begin
                offset[target][datum_sel] <= entry - raw_pos[target];
            end
        end
    end

    // settings restored once, then set by software
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            restored <= 1'b0;
            scale_factor <= SCALE_ONE;
            inch_mode <= 1'b0;
            angle_fmt <= ANG_DEC_DEG;
        end else if (clock_en) begin
            if (!restored) begin
                restored <= 1'b1;
                // bad stored factor falls back to unity
                scale_factor <= factor_ok(nv_scale_in) ? nv_scale_in : SCALE_ONE;
                inch_mode <= nv_inch_in;
                case (nv_angle_in)
                    3'h2: angle_fmt <= ANG_RADIAN;
                    3'h4: angle_fmt <= ANG_DMS;
                    default: angle_fmt <= ANG_DEC_DEG;
                endcase
            end else begin
                // out-of-range factor ignored
                if (do_write && address == ADDR_SCALE && factor_ok(write_data)) begin
                    scale_factor <= write_data;
                end
                if (cmd[CMD_UNIT]) begin
                    inch_mode <= !inch_mode;
                end
                if (cmd[CMD_ANGLE]) begin
                    case (angle_fmt)
                        ANG_DEC_DEG: angle_fmt <= ANG_RADIAN;
                        ANG_RADIAN: angle_fmt <= ANG_DMS;
                        ANG_DMS: angle_fmt <= ANG_DEC_DEG;
                        default: angle_fmt <= ANG_DEC_DEG;
                    endcase
                end
            end
        end
    end

    // store request on a kept setting change
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            nv_write <= 1'b0;
        end else if (clock_en) begin
            nv_write <= restored && (cmd[CMD_UNIT] || cmd[CMD_ANGLE]
                || (do_write && address == ADDR_SCALE && factor_ok(write_data)));
        end else begin
            nv_write <= 1'b0;
        end
    end
    assign nv_scale_out = scale_factor;
    assign nv_inch_out = inch_mode;
    assign nv_angle_out = angle_fmt;

    // indicator when scaling is not unity
    assign scale_indicator = (ctrl[CTRL_SCALE1] || ctrl[CTRL_SCALE2])
        && (scale_factor != SCALE_ONE);

    // stopwatch state: requests act at once, reset wins over toggle
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            watch_state <= SW_STOPPED;
        end else if (clock_en) begin
            case (watch_state)
                SW_STOPPED: begin
                    if (!cmd[CMD_SW_RESET] && cmd[CMD_SW_TOGGLE]) begin
                        watch_state <= SW_RUNNING;
                    end
                end
                SW_RUNNING: begin
                    if (cmd[CMD_SW_RESET] || cmd[CMD_SW_TOGGLE]) begin
                        watch_state <= SW_STOPPED;
                    end
                end
                default: watch_state <= SW_STOPPED;
            endcase
        end
    end
    assign watch_running = (watch_state == SW_RUNNING);

    // divider paused while stopped, so intervals add
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            tick_count <= 32'h0;
        end else if (clock_en) begin
            if (cmd[CMD_SW_RESET]) begin
                tick_count <= 32'h0;
            end else if (tick) begin
                tick_count <= 32'h0;
            end else if (watch_state == SW_RUNNING) begin
                tick_count <= tick_count + 32'h1;
            end
        end
    end

    // elapsed h:m:s from zero; hours saturate
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            seconds <= 6'h0;
            minutes <= 6'h0;
            hours <= 8'h0;
        end else if (clock_en) begin
            if (cmd[CMD_SW_RESET]) begin
                seconds <= 6'h0;
                minutes <= 6'h0;
                hours <= 8'h0;
            end else if (tick) begin
                if (seconds == WRAP_SIXTY) begin
                    seconds <= 6'h0;
                    if (minutes == WRAP_SIXTY) begin
                        minutes <= 6'h0;
                        if (hours != 8'hFF) begin
                            hours <= hours + 8'h1;
                        end
                    end else begin
                        minutes <= minutes + 6'h1;
                    end
                end else begin
                    seconds <= seconds + 6'h1;
                end
            end
        end
    end

    // status-bar field, registered
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            watch_field_hi <= 6'h0;
            watch_field_lo <= 6'h0;
            watch_field_hours <= 1'b0;
        end else if (clock_en) begin
            watch_field_hours <= (hours != 8'h0);
            watch_field_hi <= (hours != 8'h0) ? 6'(hours) : minutes;
            watch_field_lo <= (hours != 8'h0) ? minutes : seconds;
        end
    end

    // read data one cycle after strobe, else zero
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            read_data <= 32'h0;
        end else if (clock_en && read_strobe) begin
            case (address)
                ADDR_CTRL: read_data <= {25'h0, ctrl};
                ADDR_ENTRY: read_data <= entry;
                ADDR_SCALE: read_data <= scale_factor;
                ADDR_STATUS: read_data <= {24'h0, angle_fmt, inch_mode,
                    scale_indicator, watch_running, set_flash, entry_pending};
                ADDR_FIRST: read_data <= disp[0];
                ADDR_SECOND: read_data <= disp[1];
                ADDR_COUPLED: read_data <= coupled_value;
                ADDR_PRESET: read_data <= preset_value;
                ADDR_WATCH: read_data <= {12'h0, hours, minutes, seconds};
                ADDR_AXIS_CFG: read_data <= {30'h0, axis_linear};
                ADDR_FORMULA_K: read_data <= formula_k;
                default: read_data <= 32'h0;
            endcase
        end else begin
            read_data <= 32'h0;
        end
    end

endmodule

// ### core/datum_pkg.sv
// constants shared by the datum, scale and stopwatch logic
package datum_pkg;
    // register byte offsets
    localparam logic [7:0]
        ADDR_CTRL = 8'h00,
        ADDR_CMD = 8'h04,
        ADDR_ENTRY = 8'h08,
        ADDR_SCALE = 8'h0C,
        ADDR_STATUS = 8'h10,
        ADDR_FIRST = 8'h14,
        ADDR_SECOND = 8'h18,
        ADDR_COUPLED = 8'h1C,
        ADDR_PRESET = 8'h20,
        ADDR_WATCH = 8'h24,
        ADDR_AXIS_CFG = 8'h28,
        ADDR_FORMULA_K = 8'h2C;
    // control register fields
    localparam int
        CTRL_COUPLED = 0,
        CTRL_FORM_LO = 1,
        CTRL_DATUM = 3,
        CTRL_TARGET = 4,
        CTRL_SCALE1 = 5,
        CTRL_SCALE2 = 6;
    // command bits, one-cycle actions
    localparam int
        CMD_RESET = 0,
        CMD_PRESET = 1,
        CMD_ENTER_DISP = 2,
        CMD_ENTER_PRESET = 3,
        CMD_UNIT = 4,
        CMD_ANGLE = 5,
        CMD_SW_TOGGLE = 6,
        CMD_SW_RESET = 7,
        CMD_CANCEL = 8;
    // coupled formula selections
    localparam logic [1:0] FORM_SUM = 2'h0;
    localparam logic [1:0] FORM_DIFF = 2'h1;
    localparam logic [1:0] FORM_FIRST = 2'h2;
    // scale factor in millionths
    localparam logic signed [31:0] SCALE_ONE = 32'shF4240;
    localparam logic signed [31:0] SCALE_MIN = 32'sh186A0;
    localparam logic signed [31:0] SCALE_MAX = 32'sh989680;
    // angle format one-hot codes
    typedef enum logic [2:0] {
        ANG_DEC_DEG = 3'h1,
        ANG_RADIAN = 3'h2,
        ANG_DMS = 3'h4
    } angle_e;
    // timing
    localparam int CLOCK_PERIOD_NS = 10;
    localparam int SECOND_NS = 1000000000;
    localparam int FLASH_HALF_NS = 250000000;
    localparam int TICK_CYCLES = SECOND_NS / CLOCK_PERIOD_NS;
    localparam int FLASH_CYCLES = FLASH_HALF_NS / CLOCK_PERIOD_NS;
    localparam logic [5:0] WRAP_SIXTY = 6'h3B;
endpackage

// ### test/position_datum_scale_stopwatch_asserts.sv
// port-level assertions for the datum, scale and stopwatch block
`timescale 1ns/1ps
module position_datum_scale_stopwatch_asserts
    import datum_pkg::*;
#(
    parameter int FLASH_LEN = 4
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clock_en,
    input wire logic [7:0] address,
    input wire logic [31:0] write_data,
    input wire logic write_strobe,
    input wire logic signed [31:0] nv_scale_out,
    input wire logic set_flash,
    input wire logic scale_indicator,
    input wire logic watch_running,
    input wire logic [5:0] watch_field_hi,
    input wire logic [5:0] watch_field_lo,
    input wire logic watch_field_hours
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    logic cmd; // command word taken this cycle
    logic [31:0] flash_run; // length of flash-high phase
    assign cmd = write_strobe && clock_en && address == ADDR_CMD;
    // frozen cycles do not count
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            flash_run <= 32'h0;
        end else if (!set_flash) begin
            flash_run <= 32'h0;
        end else if (clock_en) begin
            flash_run <= flash_run + 32'h1;
        end
    end
    chk_scale_flag: assert property (scale_indicator |-> nv_scale_out != SCALE_ONE)
        else $error("scale flag at unity");
    chk_flash_span: assert property (flash_run <= FLASH_LEN)
        else $error("flash too long");
    chk_run_toggle: assert property (cmd && write_data[CMD_SW_TOGGLE] &&
        !write_data[CMD_SW_RESET] |=> watch_running != $past(watch_running))
        else $error("no toggle");
    chk_watch_clear: assert property (cmd && write_data[CMD_SW_RESET] |=>
        !watch_running ##1 (watch_field_hi == 6'h0 && watch_field_lo == 6'h0))
        else $error("reset not cleared");
    chk_run_cause: assert property ($changed(watch_running) |-> $past(cmd))
        else $error("run change uncommanded");
    chk_stop_hold: assert property ((!watch_running && !cmd) [*2] |=>
        $stable(watch_field_lo) && $stable(watch_field_hi))
        else $error("stopped watch moved");
    chk_sec_range: assert property (watch_field_lo <= WRAP_SIXTY)
        else $error("low field above 59");
    chk_min_range: assert property (!watch_field_hours |-> watch_field_hi <= WRAP_SIXTY)
        else $error("minutes above 59");
endmodule

bind position_datum_scale_stopwatch position_datum_scale_stopwatch_asserts #(
    .FLASH_LEN(FLASH_LEN)
) u_chk (
    .clock, .reset_n, .clock_en, .address, .write_data, .write_strobe, .nv_scale_out,
    .set_flash, .scale_indicator, .watch_running, .watch_field_hi, .watch_field_lo,
    .watch_field_hours
);

// ### test/encoder_switch_model.sv
// far side: length gauge counts and external switching inputs
`timescale 1ns/1ps
module encoder_switch_model (
    input wire logic clock,
    output logic signed [7:0] first_axis_delta,
    output logic signed [7:0] second_axis_delta,
    output logic ext_reset_pin,
    output logic ext_preset_pin
);
    // idle gauges report no motion, idle inputs rest low
    initial begin
        first_axis_delta = 8'sh00;
        second_axis_delta = 8'sh00;
        ext_reset_pin = 1'b0;
        ext_preset_pin = 1'b0;
    end
    // motion for n cycles
    task automatic move(input logic signed [7:0] d1, input logic signed [7:0] d2, input int n);
        repeat (n) begin
            first_axis_delta <= d1;
            second_axis_delta <= d2;
            @(posedge clock);
        end
        first_axis_delta <= 8'sh00;
        second_axis_delta <= 8'sh00;
    endtask
    // closure outlasts the synchroniser
    task automatic pulse(input logic sel);
        if (sel) ext_preset_pin <= 1'b1;
        else ext_reset_pin <= 1'b1;
        repeat (4) @(posedge clock);
        ext_preset_pin <= 1'b0;
        ext_reset_pin <= 1'b0;
    endtask
endmodule

// ### test/position_datum_scale_stopwatch_test.sv
// self-checking bench for the datum, scale and stopwatch block
`timescale 1ns/1ps
module position_datum_scale_stopwatch_test;
    import datum_pkg::*;
    typedef struct packed {logic [1:0] op; logic [7:0] addr; logic [31:0] val;} row_s;
    localparam logic [1:0] W = 2'h0, R = 2'h1, M = 2'h2; // write, read-compare, move
    logic clock, reset_n, clock_en, write_strobe, read_strobe, nv_inch_in, nv_write, nv_inch_out;
    logic [7:0] address;
    logic [31:0] write_data, read_data;
    logic signed [7:0] first_axis_delta, second_axis_delta;
    logic ext_reset_pin, ext_preset_pin, set_flash, scale_indicator, watch_running;
    logic signed [31:0] nv_scale_in, nv_scale_out;
    logic [2:0] nv_angle_in, nv_angle_out;
    logic [5:0] watch_field_hi, watch_field_lo;
    logic watch_field_hours;
    int err_count = 0;
    int total_checks = 0;
    // move rows: addr = cycles, val = {second, first} delta
    row_s rows [0:57] = '{
        '{R,ADDR_SCALE,32'h1E8480}, '{R,ADDR_STATUS,32'h50},
        '{W,ADDR_CMD,32'h10}, '{W,ADDR_CMD,32'h20}, '{R,ADDR_STATUS,32'h80},
        '{W,ADDR_CMD,32'h20}, '{R,ADDR_STATUS,32'h20},
        '{W,ADDR_CMD,32'h20}, '{R,ADDR_STATUS,32'h40},
        '{W,ADDR_ENTRY,32'h123}, '{R,ADDR_STATUS,32'h43},
        '{W,ADDR_CMD,32'h8}, '{R,ADDR_PRESET,32'h123}, '{R,ADDR_STATUS,32'h40},
        '{W,ADDR_CTRL,32'h1}, '{W,ADDR_FORMULA_K,32'h7}, '{M,8'h1,32'hFF06},
        '{R,ADDR_COUPLED,32'h4C4B47},
        '{W,ADDR_CMD,32'h2}, '{R,ADDR_FIRST,32'h123}, '{R,ADDR_SECOND,32'h0},
        '{M,8'h1,32'h200}, '{W,ADDR_ENTRY,32'h55}, '{W,ADDR_CMD,32'h4},
        '{R,ADDR_FIRST,32'h55}, '{R,ADDR_SECOND,32'h0},
        '{W,ADDR_ENTRY,32'h99}, '{W,ADDR_CMD,32'h100}, '{W,ADDR_CMD,32'h4},
        '{R,ADDR_FIRST,32'h55},
        '{W,ADDR_CMD,32'h1}, '{R,ADDR_FIRST,32'h0}, '{R,ADDR_SECOND,32'h0},
        '{R,ADDR_COUPLED,32'h7},
        '{W,ADDR_SCALE,32'hFFE91CA0}, '{W,ADDR_CTRL,32'h21}, '{R,ADDR_STATUS,32'h48},
        '{M,8'h1,32'h02}, '{R,ADDR_FIRST,32'hFFD23940},
        '{W,ADDR_SCALE,32'h1869F}, '{W,ADDR_SCALE,32'h989681},
        '{R,ADDR_SCALE,32'hFFE91CA0},
        '{W,ADDR_SCALE,32'h186A0}, '{R,ADDR_SCALE,32'h186A0},
        '{W,ADDR_SCALE,32'hFF676980}, '{R,ADDR_SCALE,32'hFF676980},
        '{W,ADDR_AXIS_CFG,32'h0}, '{W,ADDR_CTRL,32'h61}, '{R,ADDR_CTRL,32'h1},
        '{R,ADDR_STATUS,32'h40},
        '{W,ADDR_CTRL,32'h9}, '{W,ADDR_CMD,32'h1}, '{R,ADDR_FIRST,32'h0},
        '{W,ADDR_CTRL,32'h1}, '{R,ADDR_FIRST,32'hFFD23940},
        '{R,8'h30,32'h0}, '{W,8'h30,32'h5}, '{R,ADDR_CTRL,32'h1}
    };
    // short counts keep the hour test cheap
    position_datum_scale_stopwatch #(.TICK_LEN(10), .FLASH_LEN(4)) u_dut (
        .clock, .reset_n, .clock_en, .address, .write_data, .write_strobe, .read_strobe,
        .read_data, .first_axis_delta, .second_axis_delta, .ext_reset_pin, .ext_preset_pin,
        .nv_scale_in, .nv_inch_in, .nv_angle_in, .nv_write, .nv_scale_out, .nv_inch_out,
        .nv_angle_out, .set_flash, .scale_indicator, .watch_running, .watch_field_hi,
        .watch_field_lo, .watch_field_hours
    );
    encoder_switch_model u_far (
        .clock, .first_axis_delta, .second_axis_delta, .ext_reset_pin, .ext_preset_pin
    );
    // 100 MHz system clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // quiet edge after each strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        address <= a;
        write_data <= d;
        write_strobe <= 1'b1;
        @(posedge clock);
        write_strobe <= 1'b0;
        @(posedge clock);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // data stand one cycle
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        address <= a;
        read_strobe <= 1'b1;
        @(posedge clock);
        read_strobe <= 1'b0;
        #1 chk(read_data, e);
        @(posedge clock);
    endtask
    task automatic test_done;
        $display("TB: %0d checks %0d errors", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // watchdog past the ~36000 cycles needed
    initial begin
        repeat (45000) @(posedge clock);
        err_count++;
        test_done();
    end
    initial begin
        reset_n = 1'b0;
        clock_en = 1'b1;
        address = 8'h00;
        write_data = 32'h0;
        write_strobe = 1'b0;
        read_strobe = 1'b0;
        nv_scale_in = 32'sh1E8480;
        nv_inch_in = 1'b1;
        nv_angle_in = 3'h2;
        repeat (5) @(posedge clock);
        chk(nv_scale_out, SCALE_ONE);
        chk({29'h0, nv_angle_out}, 32'h1);
        reset_n <= 1'b1;
        repeat (3) @(posedge clock);
        foreach (rows[i]) begin
            if (rows[i].op == W) wr(rows[i].addr, rows[i].val);
            else if (rows[i].op == R) rdchk(rows[i].addr, rows[i].val);
            else u_far.move(rows[i].val[7:0], rows[i].val[15:8], int'(rows[i].addr));
        end
        $display("TB: table done");
        chk({31'h0, nv_inch_out}, 32'h0);
        u_far.move(8'sh01, 8'sh01, 1);
        u_far.pulse(1'b0);
        repeat (6) @(posedge clock);
        rdchk(ADDR_FIRST, 32'h0);
        rdchk(ADDR_SECOND, 32'h0);
        u_far.pulse(1'b1);
        repeat (6) @(posedge clock);
        rdchk(ADDR_FIRST, 32'h123);
        $display("TB: pins done");
        wr(ADDR_CMD, 32'h40);
        #1 chk({31'h0, watch_running}, 32'h1);
        repeat (33) @(posedge clock);
        wr(ADDR_CMD, 32'h40);
        #1 chk({31'h0, watch_running}, 32'h0);
        repeat (20) @(posedge clock);
        rdchk(ADDR_WATCH, 32'h3);
        #1 chk({26'h0, watch_field_lo}, 32'h3);
        @(posedge clock);
        wr(ADDR_CMD, 32'h40);
        repeat (18) @(posedge clock);
        wr(ADDR_CMD, 32'h40);
        rdchk(ADDR_WATCH, 32'h5);
        wr(ADDR_CMD, 32'h40);
        repeat (595) @(posedge clock);
        rdchk(ADDR_WATCH, 32'h45);
        #1 chk({20'h0, watch_field_hi, watch_field_lo}, 32'h45);
        repeat (35395) @(posedge clock);
        rdchk(ADDR_WATCH, 32'h1004);
        #1 chk({19'h0, watch_field_hours, watch_field_hi, watch_field_lo}, 32'h1040);
        @(posedge clock);
        wr(ADDR_CMD, 32'h80);
        #1 chk({31'h0, watch_running}, 32'h0);
        @(posedge clock);
        rdchk(ADDR_WATCH, 32'h0);
        $display("TB: watch done");
        test_done();
    end
endmodule
